// ### prbc_defines.vh
// constants for the power, reset and brown-out controller
// Summary of operation
// RULE1: power register writable anytime, acts at once
// RULE2: fast oscillator clock gated cleanly before power-down
// RULE3: bit0 fast oscillator output off, resets 0
// RULE4: bit1 fast oscillator core off, resets 0
// RULE5: 32-bit register; bit2 flash, bit3 brownout
// RULE6: bit4 converter off, resets to 1
// RULE7: bit6 slow oscillator; lock ignores power-down
// RULE8: software writes zeros to bits 14:7
// RULE9: bit15 comparator off, resets to 1
// RULE10: read-only 32-bit part identifier register
// RULE11: five reset sources merged into chip reset
// RULE12: hold reset until pin released, oscillator runs
// RULE13: processor fetches from address zero after reset
// RULE14: registers hold reset values at release
// RULE15: brownout compares supply against selectable threshold
// RULE16: brownout resets if enabled, else interrupts
// RULE17: brownout level readable from status register
// RULE18: brownout interrupt wakes when both enables set
// RULE19: brownout reset also wakes the chip
// RULE20: bit5 reads 1, upper bits read 0
`ifndef PRBC_DEFINES_VH
`define PRBC_DEFINES_VH
// ==========================================
// register offsets (byte addresses)
`define PRBC_RUN_POWER_CONFIG_ADDR 32'h40048238
`define PRBC_PART_IDENTIFIER_ADDR 32'h400483f8
`define PRBC_BROWNOUT_CTRL_ADDR 32'h40048150
`define PRBC_BROWNOUT_STATUS_ADDR 32'h40048154
// ==========================================
// power configuration fields
`define PRBC_FAST_OSC_OUTPUT_OFF_BIT 0
`define PRBC_FAST_OSC_CORE_OFF_BIT 1
`define PRBC_FLASH_OFF_BIT 2
`define PRBC_BROWNOUT_DETECTOR_OFF_BIT 3
`define PRBC_CONVERTER_OFF_BIT 4
`define PRBC_SLOW_OSC_OFF_BIT 6
`define PRBC_COMPARATOR_OFF_BIT 15
`define PRBC_RUN_POWER_CONFIG_RESET 16'h8070
`define PRBC_RUN_POWER_CONFIG_WMASK 16'h805f
// ==========================================
// brown-out control fields
`define PRBC_BROWNOUT_LEVEL_LSB 0
`define PRBC_BROWNOUT_LEVEL_MSB 1
`define PRBC_BROWNOUT_RESET_ENABLE_BIT 4
`define PRBC_BROWNOUT_CTRL_RESET 5'h00
// ==========================================
// timing
`define PRBC_CLK_MHZ 50
`define PRBC_RESET_STRETCH_NS 320
`define PRBC_RESET_STRETCH_CYCLES ((`PRBC_RESET_STRETCH_NS * `PRBC_CLK_MHZ + 999) / 1000)
`define PRBC_BOOT_VECTOR 32'h00000000
`endif

// ### prbc_power_reset_ctrl.v
// power configuration, part identifier, reset merge and brown-out logic
//
// Implementation choice: register access over Wishbone.
`include "prbc_defines.vh"

module prbc_power_reset_ctrl #(
   parameter [31:0] PART_ID = 32'h0000_5a5a, // arbitrary value
   parameter STRETCH = `PRBC_RESET_STRETCH_CYCLES
) (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o,
   // reset sources
   input wire reset_pin_b,
   input wire watchdog_reset,
   input wire power_on_reset,
   input wire software_reset_req,
   // oscillator and watchdog lock
   input wire fast_osc_running,
   input wire watchdog_lock,
   // brown-out detector
   input wire [2:0] supply_below_level,
   input wire brownout_wake_enable,
   input wire brownout_irq_enabled,
   input wire in_deep_sleep,
   // power controls
   output reg fast_osc_output_off,
   output reg fast_osc_core_off,
   output reg fast_osc_clk_gate,
   output reg flash_off,
   output reg brownout_detector_off,
   output reg converter_off,
   output reg slow_osc_off,
   output reg comparator_off,
   // chip reset and brown-out outputs
   output reg chip_reset_b,
   output reg fast_osc_start,
   output reg [31:0] boot_fetch_addr,
   output reg brownout_irq,
   output reg wake_request
);

// ==========================================
// reset release and input synchronisers
reg [1:0] rst_sync;
wire rst_n;
always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      rst_sync <= 2'h0;
   end else begin
      rst_sync <= {rst_sync[0], 1'b1};
   end
end
assign rst_n = rst_sync[1];

// every reset source, oscillator, lock and analog level input passes two flops before use; the sleep and wake enables do not
localparam NSYNC = 9;
wire [NSYNC-1:0] async_in;
reg [NSYNC-1:0] sync_a;
reg [NSYNC-1:0] sync_b;
assign async_in = {reset_pin_b, watchdog_reset, power_on_reset, software_reset_req,
                   fast_osc_running, watchdog_lock, supply_below_level};
genvar gi;
generate
   for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            sync_a[gi] <= 1'b0;
            sync_b[gi] <= 1'b0;
         end else begin
            sync_a[gi] <= async_in[gi];
            sync_b[gi] <= sync_a[gi];
         end
      end
   end
endgenerate
wire pin_b_s = sync_b[8];
wire wdt_s = sync_b[7];
wire por_s = sync_b[6];
wire swr_s = sync_b[5];
wire osc_run_s = sync_b[4];
wire lock_s = sync_b[3];
wire [2:0] below_s = sync_b[2:0];

// ==========================================
// wishbone decode, single-cycle ack
reg ack;
wire req = wb_cyc_i && wb_stb_i && !ack;
wire hit_pwr = (wb_adr_i == `PRBC_RUN_POWER_CONFIG_ADDR);
wire hit_id = (wb_adr_i == `PRBC_PART_IDENTIFIER_ADDR);
wire hit_bctl = (wb_adr_i == `PRBC_BROWNOUT_CTRL_ADDR);
wire hit_bst = (wb_adr_i == `PRBC_BROWNOUT_STATUS_ADDR);
wire mapped = hit_pwr || hit_id || hit_bctl || hit_bst;
reg err;
assign wb_ack_o = ack;
assign wb_err_o = err;
wire wr = req && mapped && wb_we_i;

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      ack <= 1'b0;
      err <= 1'b0;
   end else begin
      ack <= req && mapped;
      err <= req && !mapped && !err;
   end
end

// ==========================================
// power configuration register
reg [15:0] run_power_config;
reg [4:0] brownout_ctrl;
wire [15:0] wmask = `PRBC_RUN_POWER_CONFIG_WMASK;
wire [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
reg [15:0] next_run_power_config;

always @* begin
   // reserved bits are not writable; software should write them zero anyway (see RULE8)
   next_run_power_config = (run_power_config & ~(wmask & lane_mask)) |
                           (wb_dat_i[15:0] & wmask & lane_mask); // see RULE1 see RULE20
   // watchdog lock keeps the slow oscillator running
   if (lock_s) begin
      next_run_power_config[`PRBC_SLOW_OSC_OFF_BIT] = 1'b0; // see RULE7
   end
end

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      run_power_config <= `PRBC_RUN_POWER_CONFIG_RESET; // see RULE3 see RULE4 see RULE5
      brownout_ctrl <= `PRBC_BROWNOUT_CTRL_RESET;
   end else if (chip_reset_b == 1'b0) begin
      // both configuration registers back to their defined values before release
      run_power_config <= `PRBC_RUN_POWER_CONFIG_RESET; // see RULE14
      brownout_ctrl <= `PRBC_BROWNOUT_CTRL_RESET;
   end else begin
      if (wr && hit_pwr) begin
         run_power_config <= next_run_power_config;
      end else if (lock_s) begin
         run_power_config[`PRBC_SLOW_OSC_OFF_BIT] <= 1'b0; // see RULE7
      end
      if (wr && hit_bctl && wb_sel_i[0]) begin
         brownout_ctrl <= wb_dat_i[4:0];
      end
   end
end

// ==========================================
// power outputs: all immediate except the oscillator core
reg [1:0] gate_state;
localparam GATE_RUN = 2'h1;
localparam GATE_STOP = 2'h2;
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      fast_osc_output_off <= 1'b0;
      flash_off <= 1'b0;
      brownout_detector_off <= 1'b0;
      converter_off <= 1'b1;
      slow_osc_off <= 1'b1;
      comparator_off <= 1'b1;
      fast_osc_core_off <= 1'b0;
      fast_osc_clk_gate <= 1'b0;
      gate_state <= GATE_RUN;
   end else begin
      fast_osc_output_off <= run_power_config[`PRBC_FAST_OSC_OUTPUT_OFF_BIT]; // see RULE3
      flash_off <= run_power_config[`PRBC_FLASH_OFF_BIT]; // see RULE5
      brownout_detector_off <= run_power_config[`PRBC_BROWNOUT_DETECTOR_OFF_BIT]; // see RULE5
      converter_off <= run_power_config[`PRBC_CONVERTER_OFF_BIT]; // see RULE6
      slow_osc_off <= run_power_config[`PRBC_SLOW_OSC_OFF_BIT] && !lock_s; // see RULE7
      comparator_off <= run_power_config[`PRBC_COMPARATOR_OFF_BIT]; // see RULE9
      // the core powers down only after its clock gate has closed a cycle earlier
      case (gate_state)
         GATE_RUN: begin
            fast_osc_core_off <= 1'b0;
            if (run_power_config[`PRBC_FAST_OSC_CORE_OFF_BIT]) begin
               fast_osc_clk_gate <= 1'b1; // see RULE2
               gate_state <= GATE_STOP;
            end else begin
               fast_osc_clk_gate <= 1'b0;
            end
         end
         GATE_STOP: begin
            if (!run_power_config[`PRBC_FAST_OSC_CORE_OFF_BIT]) begin
               fast_osc_core_off <= 1'b0;
               gate_state <= GATE_RUN;
            end else begin
               fast_osc_core_off <= 1'b1; // see RULE2 see RULE4
            end
         end
         default: begin
            gate_state <= GATE_RUN;
         end
      endcase
   end
end

// ==========================================
// brown-out detection
wire [1:0] level_sel = brownout_ctrl[`PRBC_BROWNOUT_LEVEL_MSB:`PRBC_BROWNOUT_LEVEL_LSB];
wire brownout_reset_enable = brownout_ctrl[`PRBC_BROWNOUT_RESET_ENABLE_BIT];
// select value 3 is out of range and never fires
wire brownout_event = !brownout_detector_off && (level_sel != 2'h3) &&
                      below_s[level_sel]; // see RULE15
wire brownout_reset = brownout_event && brownout_reset_enable; // see RULE16

always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      brownout_irq <= 1'b0;
      wake_request <= 1'b0;
   end else begin
      brownout_irq <= brownout_event && !brownout_reset_enable; // see RULE16
      wake_request <= in_deep_sleep && ((brownout_event && !brownout_reset_enable &&
                      brownout_wake_enable && brownout_irq_enabled) || // see RULE18
                      brownout_reset); // see RULE19
   end
end

// ==========================================
// reset merge and stretch
wire any_source = !pin_b_s || wdt_s || por_s || brownout_reset || swr_s; // see RULE11
reg [7:0] stretch;
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      chip_reset_b <= 1'b0;
      fast_osc_start <= 1'b1;
      stretch <= 8'h00;
      boot_fetch_addr <= `PRBC_BOOT_VECTOR;
   end else begin
      if (any_source) begin
         chip_reset_b <= 1'b0;
         fast_osc_start <= 1'b1; // see RULE12
         stretch <= 8'h00;
      end else if (!chip_reset_b) begin
         // pin released and oscillator running, then a short settle
         if (osc_run_s && stretch >= STRETCH[7:0]) begin
            chip_reset_b <= 1'b1; // see RULE12
            fast_osc_start <= 1'b0;
         end else if (osc_run_s) begin
            stretch <= stretch + 8'h01;
         end
      end
      boot_fetch_addr <= `PRBC_BOOT_VECTOR; // see RULE13
   end
end

// ==========================================
// read data
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      wb_dat_o <= 32'h0;
   end else if (req && !wb_we_i) begin
      if (hit_pwr) begin
         wb_dat_o <= {16'h0, run_power_config}; // see RULE20
      end else if (hit_id) begin
         wb_dat_o <= PART_ID; // see RULE10
      end else if (hit_bctl) begin
         wb_dat_o <= {27'h0, brownout_ctrl};
      end else if (hit_bst) begin
         wb_dat_o <= {31'h0, brownout_event}; // see RULE17
      end else begin
         wb_dat_o <= 32'h0;
      end
   end
end

endmodule // prbc_power_reset_ctrl

// ### prbc_monitor.sv
// assertion checker for the power, reset and brown-out controller
module prbc_monitor (
   // clock and bus
   input wire core_clk,
   input wire rst_b,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_adr_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   // reset, oscillator and brown-out
   input wire reset_pin_b,
   input wire fast_osc_running,
   input wire watchdog_lock,
   input wire brownout_wake_enable,
   input wire brownout_irq_enabled,
   input wire in_deep_sleep,
   input wire fast_osc_clk_gate,
   input wire fast_osc_core_off,
   input wire slow_osc_off,
   input wire chip_reset_b,
   input wire fast_osc_start,
   input wire [31:0] boot_fetch_addr,
   input wire brownout_irq,
   input wire wake_request
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_power_req;
      s_taken ##0 (wb_adr_i == 32'h4004_8238);
   endsequence
   a_mapped_ack: assert property (s_power_req |=> wb_ack_o && !wb_err_o)
      else $error("no ack");
   a_gate_first: assert property ($rose(fast_osc_core_off) |-> $past(fast_osc_clk_gate))
      else $error("core off before gate");
   a_boot_zero: assert property (chip_reset_b |-> boot_fetch_addr == 32'h0)
      else $error("boot address");
   a_osc_started: assert property ($fell(chip_reset_b) |-> ##[0:1] fast_osc_start)
      else $error("oscillator not started");
   // the pin passes two sync flops and one register before it shows
   a_pin_holds: assert property (!reset_pin_b [*4] |-> !chip_reset_b)
      else $error("pin reset lost");
   a_release_ready: assert property ($rose(chip_reset_b) |-> reset_pin_b && fast_osc_running)
      else $error("early release");
   a_irq_wakes: assert property (brownout_irq && brownout_wake_enable && brownout_irq_enabled
      && in_deep_sleep |-> ##[0:2] wake_request)
      else $error("no wake");
   // the lock passes two sync flops, then the output register samples it
   a_lock_keeps: assert property ($rose(slow_osc_off) |-> !$past(watchdog_lock, 3))
      else $error("slow osc stopped under lock");
endmodule // prbc_monitor

bind prbc_power_reset_ctrl prbc_monitor i_monitor (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_adr_i, .wb_ack_o, .wb_err_o, .reset_pin_b, .fast_osc_running, .watchdog_lock,
   .brownout_wake_enable, .brownout_irq_enabled, .in_deep_sleep, .fast_osc_clk_gate,
   .fast_osc_core_off, .slow_osc_off, .chip_reset_b, .fast_osc_start, .boot_fetch_addr,
   .brownout_irq, .wake_request);

// ### testbench.sv
// self-checking bench for the power, reset and brown-out controller
`include "prbc_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // stimulus and observation
   localparam [31:0] PID = 32'h0000_1234; // arbitrary value
   localparam [31:0] PWR = `PRBC_RUN_POWER_CONFIG_ADDR;
   localparam [31:0] IDA = `PRBC_PART_IDENTIFIER_ADDR;
   localparam [31:0] CTL = `PRBC_BROWNOUT_CTRL_ADDR;
   logic core_clk = 1'h0, rst_b = 1'h0, req = 1'h0, we = 1'h0, osc = 1'h0, lock = 1'h0;
   logic [31:0] adr = 32'h0, dat = 32'h0;
   logic [3:0] src = 4'h8, sel = 4'hf;
   logic [2:0] below = 3'h0, wk = 3'h0;
   logic [31:0] rdat, boot, rq;
   logic ack, err, osc_start, re;
   wire [7:0] pw;
   wire [2:0] st;
   int checks_done = 0, fail_count = 0;
   always #10 core_clk = ~core_clk;
   // a stretch of one keeps every release wait short
   prbc_power_reset_ctrl #(.PART_ID(PID), .STRETCH(1)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .reset_pin_b(!src[3]), .watchdog_reset(src[0]), .power_on_reset(src[1]),
      .software_reset_req(src[2]), .fast_osc_running(osc), .watchdog_lock(lock),
      .supply_below_level(below), .brownout_wake_enable(wk[0]), .brownout_irq_enabled(wk[1]),
      .in_deep_sleep(wk[2]), .fast_osc_output_off(pw[0]), .fast_osc_core_off(pw[1]),
      .fast_osc_clk_gate(pw[5]), .flash_off(pw[2]), .brownout_detector_off(pw[3]),
      .converter_off(pw[4]), .slow_osc_off(pw[6]), .comparator_off(pw[7]),
      .chip_reset_b(st[0]), .fast_osc_start(osc_start), .boot_fetch_addr(boot),
      .brownout_irq(st[1]), .wake_request(st[2]));
   // ==========================================
   // tasks
   task automatic check(input string s, input logic [31:0] x, y);
      checks_done++;
      if (x !== y) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", s, x, y);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s = 4'hf);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= 1'h1;
      we <= w;
      sel <= s;
      adr <= a;
      dat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'h1 && err !== 1'h1 && n < 20);
      rq = rdat;
      re = err;
      req <= 1'h0;
      check("answer", 1'h1, ack | err);
   endtask
   task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hf);
      bus(1'h1, a, d, s);
      check("error", 1'h0, re);
   endtask
   task automatic rd(input logic [31:0] a, x);
      bus(1'h0, a, 32'h0);
      check("read", x, rq);
   endtask
   task automatic await(input int b, input logic v, input string s);
      int n;
      n = 0;
      while (st[b] !== v && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      check(s, v, st[b]);
   endtask
   task automatic t_start;
      repeat (20) @(posedge core_clk);
      check("reset", 1'h0, st[0]);
      check("osc start", 1'h1, osc_start);
      src <= 4'h0;
      repeat (20) @(posedge core_clk);
      check("reset", 1'h0, st[0]);
      osc <= 1'h1;
      await(0, 1'h1, "reset");
      check("osc start", 1'h0, osc_start);
      check("boot", 32'h0, boot);
      rd(PWR, 32'h8070);
      check("power", 8'hd0, pw);
      rd(IDA, PID);
      $display("start test done");
   endtask
   task automatic t_write;
      wr(PWR, 32'hffff_807f);
      rd(PWR, 32'h807f);
      check("power", 8'hff, pw);
      wr(IDA, 32'h0);
      rd(IDA, PID);
      wr(PWR, 32'h0);
      rd(PWR, 32'h20);
      check("power", 8'h00, pw);
      wr(PWR, 32'h805f, 4'h2);
      rd(PWR, 32'h8020);
      check("power", 8'h80, pw);
      bus(1'h0, 32'h4004_8000, 32'h0);
      check("unmapped", 1'h1, re);
      $display("write test done");
   endtask
   task automatic t_lock;
      lock <= 1'h1;
      repeat (4) @(posedge core_clk);
      wr(PWR, 32'h40);
      rd(PWR, 32'h20);
      check("slow osc", 1'h0, pw[6]);
      lock <= 1'h0;
      repeat (4) @(posedge core_clk);
      $display("lock test done");
   endtask
   task automatic t_brown;
      for (int n = 0; n < 3; n++) begin
         wr(CTL, n);
         below <= 3'h1 << n;
         await(1, 1'h1, "irq");
         rd(`PRBC_BROWNOUT_STATUS_ADDR, 32'h1);
         below <= 3'h1 << ((n + 1) % 3);
         await(1, 1'h0, "irq");
      end
      wk <= 3'h7;
      below <= 3'h4;
      await(2, 1'h1, "wake");
      below <= 3'h0;
      wk <= 3'h0;
      wk <= 3'h4;
      wr(CTL, 32'h10);
      below <= 3'h1;
      await(2, 1'h1, "wake");
      await(0, 1'h0, "reset");
      below <= 3'h0;
      wk <= 3'h0;
      await(0, 1'h1, "reset");
      rd(PWR, 32'h8070);
      rd(CTL, 32'h0);
      $display("brownout test done");
   endtask
   task automatic t_src;
      for (int i = 0; i < 4; i++) begin
         src <= 4'h1 << i;
         await(0, 1'h0, "reset");
         repeat (2) @(posedge core_clk);
         check("osc start", 1'h1, osc_start);
         src <= 4'h0;
         await(0, 1'h1, "reset");
      end
      $display("source test done");
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'h1;
      t_start();
      t_write();
      t_lock();
      t_brown();
      t_src();
      stop_test();
   end
   // the whole run needs under a tenth of this span
   initial begin
      #50us;
      fail_count++;
      stop_test();
   end
endmodule // testbench
